// [hw/fid_map.svh]
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: APB byte addresses, pclk period of 8 ns
// Notes:   Included by the core only
`ifndef FID_MAP_SVH
`define FID_MAP_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define FID_OFS_PROT    8'h00
`define FID_OFS_STATUS  8'h04

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define FID_PROT_BP_LSB  0
`define FID_PROT_CMP     3
`define FID_PROT_RESET   4'h0
`define FID_ST_BUSY      0
`define FID_ST_WEL       1
`define FID_ST_PM_LSB    2

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define FID_CLK_NS          8
`define FID_T_SLEEP_NS      3000
`define FID_T_WAKE_NS       3000
`define FID_T_WAKE_ID_NS    8000
`define FID_T_ERASE_MS      40
`define FID_SLEEP_CYC       (`FID_T_SLEEP_NS / `FID_CLK_NS)
`define FID_WAKE_CYC        (`FID_T_WAKE_NS / `FID_CLK_NS)
`define FID_WAKE_ID_CYC     (`FID_T_WAKE_ID_NS / `FID_CLK_NS)
`define FID_ERASE_CYC       (`FID_T_ERASE_MS * 1000000 / `FID_CLK_NS)
`define FID_ADDR_BITS       24
`define FID_DUMMY_BITS      24

`endif

// [hw/fid_pkg.sv]
// Purpose: Types shared by the identification and erase core
// Assumes: Nothing
// Notes:   Opcodes are fixed serial flash encodings
package fid_pkg;

	typedef enum logic [7:0]
	{
		OP_WRITE_UNLOCK = 8'h06,
		OP_ERASE_A      = 8'h60,
		OP_ERASE_B      = 8'hc7,
		OP_DEEP_SLEEP   = 8'hb9,
		OP_WAKE_AND_ID  = 8'hab,
		OP_ID_SINGLE    = 8'h90,
		OP_ID_DUAL      = 8'h92,
		OP_ID_QUAD      = 8'h94,
		OP_FULL_ID      = 8'h9f
	} fid_op_t;

	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'b000,
		ST_CMD   = 3'b001,
		ST_ADDR  = 3'b010,
		ST_DUMMY = 3'b011,
		ST_OUT   = 3'b100,
		ST_END   = 3'b101,
		ST_DROP  = 3'b110
	} fid_ser_t;

	typedef enum logic [1:0]
	{
		PM_ACTIVE = 2'b00,
		PM_ENTER  = 2'b01,
		PM_SLEEP  = 2'b10,
		PM_WAKE   = 2'b11
	} fid_pm_t;

endpackage

// [hw/fid_sync.sv]
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs asynchronous to pclk
// Notes:   First stage feeds only the second
`timescale 1ns/1ns
`default_nettype none

module fid_sync
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [5:0] din,
	output logic      [5:0] dout
);

	logic [5:0] meta;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta <= 6'h01;
			dout <= 6'h01;
		end
		else
		begin
			meta <= din;
			dout <= meta;
		end
	end

endmodule // fid_sync

`default_nettype wire

// [hw/fid_timer.sv]
// Purpose: Self-timed delay counter
// Assumes: Load value of at least one
// Notes:   Done pulses one cycle when the count expires
`timescale 1ns/1ns
`default_nettype none

module fid_timer
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        start,
	input  wire logic [31:0] load,
	output logic             done
);

	logic [31:0] cnt;
	logic [31:0] next_cnt;
	logic        next_done;

	always_comb
	begin
		next_cnt  = cnt;
		next_done = 1'b0;
		if (start)
			next_cnt = load;
		else if (cnt != 32'h0)
		begin
			next_cnt  = cnt - 32'h1;
			next_done = (cnt == 32'h1);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt  <= 32'h0;
			done <= 1'b0;
		end
		else
		begin
			cnt  <= next_cnt;
			done <= next_done;
		end
	end

endmodule // fid_timer

`default_nettype wire

// [hw/fid_core.sv]
// Purpose: Serial flash erase, deep sleep and identification commands
// Assumes: Pins sampled by pclk; sclk far slower than pclk
// Notes:   Protect bits come from APB; status readable over APB
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "fid_map.svh"

// Summary of operation
// - Full erase accepts opcode 60h or c7h, opcode only.
// - Full erase needs the write enable latch set beforehand.
// - Select must rise right after the eighth opcode bit, else discarded.
// - Valid erase sets busy until timer ends; latch clears at start.
// - Erase only with protect bits all 0/comp 0 or all 1/comp 1.
// - Deep sleep ignores all commands except the wake command.
// - Sleep opcode alone; sleep entered after a delay following select rise.
// - Sleep command refused while busy; running cycle unaffected.
// - Plain deselect gives standby, never deep sleep.
// - Reset (power-up) always comes up awake.
// - Bare wake opcode leaves deep sleep after the wake delay.
// - Wake opcode plus three dummy bytes repeats the device byte.
// - Wake with ID readout from sleep uses the longer wake delay.
// - Wake command ignored while busy.
// - 90h with address bit0 0: maker then device, else reversed.
// - 92h behaves the same over two lines.
// - 94h behaves the same over four lines.
// - 9fh shifts out maker, memory type, capacity bytes.
// - 9fh not decoded while busy.
// - Select rise ends any readout and returns to standby.
module fid_core
#(
	parameter logic [31:0] ERASE_CYCLES = 32'(`FID_ERASE_CYC),
	parameter logic [7:0]  MAKER_ID     = 8'h5a, // Arbitrary value
	parameter logic [7:0]  MEM_TYPE     = 8'h3c, // Arbitrary value
	parameter logic [7:0]  CAPACITY     = 8'h18, // Arbitrary value
	parameter logic [7:0]  DEVICE_ID    = 8'h17  // Arbitrary value
)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic [3:0]  io_in,
	output logic      [3:0]  io_out,
	output logic      [3:0]  io_oe
);

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [23:0] shift_in(logic [23:0] v, logic [3:0] io,
		logic [2:0] w);
		unique case (w)
			3'd1:    shift_in = {v[22:0], io[0]};
			3'd2:    shift_in = {v[21:0], io[1:0]};
			default: shift_in = {v[19:0], io};
		endcase
	endfunction

	function automatic logic [3:0] lane_oe(logic [2:0] w);
		unique case (w)
			3'd1:    lane_oe = 4'h2;
			3'd2:    lane_oe = 4'h3;
			default: lane_oe = 4'hf;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// Pin sampling
	// ---------------------------------------------------------------
	logic [5:0] pins;
	logic       cs_q;
	logic       sclk_q;

	fid_sync u_sync
	(
		.pclk    (pclk),
		.presetn (presetn),
		.din     ({io_in, sclk, cs_n}),
		.dout    (pins)
	);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cs_q   <= 1'b1;
			sclk_q <= 1'b0;
		end
		else
		begin
			cs_q   <= pins[0];
			sclk_q <= pins[1];
		end
	end

	logic       cs_fall;
	logic       cs_rise;
	logic       sck_rise;
	logic       sck_fall;
	logic [3:0] io_s;

	assign io_s     = pins[5:2];
	assign cs_fall  = cs_q & ~pins[0];
	assign cs_rise  = ~cs_q & pins[0];
	assign sck_rise = ~pins[0] & ~sclk_q & pins[1];
	assign sck_fall = ~pins[0] & sclk_q & ~pins[1];

	// ---------------------------------------------------------------
	// Serial command engine
	// ---------------------------------------------------------------
	fid_pkg::fid_ser_t st;
	fid_pkg::fid_ser_t next_st;
	fid_pkg::fid_pm_t  pm;
	logic [7:0]  cmd,   next_cmd;
	logic [4:0]  bitcnt, next_bitcnt;
	logic [2:0]  lanes, next_lanes;
	logic [23:0] addr,  next_addr;
	logic [23:0] sr,    next_sr;
	logic [23:0] pat,   next_pat;
	logic [4:0]  plen,  next_plen;
	logic [4:0]  ocnt,  next_ocnt;
	logic [3:0]  next_io_out;
	logic [3:0]  next_io_oe;
	logic        busy;
	logic        allowed;
	logic [23:0] cur;
	logic        go_erase;
	logic        go_unlock;
	logic        go_sleep;
	logic        go_wake;
	logic        go_wake_id;

	always_comb
	begin
		next_st     = st;
		next_cmd    = cmd;
		next_bitcnt = bitcnt;
		next_lanes  = lanes;
		next_addr   = addr;
		next_sr     = sr;
		next_pat    = pat;
		next_plen   = plen;
		next_ocnt   = ocnt;
		next_io_out = io_out;
		next_io_oe  = io_oe;
		allowed     = 1'b0;
		cur         = (ocnt == 5'd0) ? pat : sr;
		if (cs_rise)
		begin
			next_st    = fid_pkg::ST_IDLE;
			next_io_oe = 4'h0;
		end
		else if (cs_fall)
		begin
			next_st     = fid_pkg::ST_CMD;
			next_bitcnt = 5'd0;
			next_lanes  = 3'd1;
		end
		else if (sck_rise)
		begin
			unique case (st)
				fid_pkg::ST_CMD:
				begin
					next_cmd    = 8'(shift_in({16'h0, cmd}, io_s, 3'd1));
					next_bitcnt = bitcnt + 5'd1;
					// Sleep admits only the wake opcode; busy admits none
					allowed = !busy && (pm == fid_pkg::PM_ACTIVE
						|| (pm == fid_pkg::PM_SLEEP
						&& next_cmd == fid_pkg::OP_WAKE_AND_ID));
					if (bitcnt == 5'd7)
					begin
						next_bitcnt = 5'd0;
						next_st     = fid_pkg::ST_DROP;
						next_ocnt   = 5'd0;
						if (allowed)
						begin
							unique case (next_cmd)
								fid_pkg::OP_WRITE_UNLOCK, fid_pkg::OP_ERASE_A,
								fid_pkg::OP_ERASE_B, fid_pkg::OP_DEEP_SLEEP:
									next_st = fid_pkg::ST_END;
								fid_pkg::OP_WAKE_AND_ID:
									next_st = fid_pkg::ST_DUMMY;
								fid_pkg::OP_ID_SINGLE:
									next_st = fid_pkg::ST_ADDR;
								fid_pkg::OP_ID_DUAL:
								begin
									next_st    = fid_pkg::ST_ADDR;
									next_lanes = 3'd2;
								end
								fid_pkg::OP_ID_QUAD:
								begin
									next_st    = fid_pkg::ST_ADDR;
									next_lanes = 3'd4;
								end
								fid_pkg::OP_FULL_ID:
								begin
									next_st   = fid_pkg::ST_OUT;
									next_pat  = {MAKER_ID, MEM_TYPE, CAPACITY};
									next_plen = 5'd24;
								end
								default:
									next_st = fid_pkg::ST_DROP;
							endcase
						end
					end
				end
				fid_pkg::ST_ADDR:
				begin
					next_addr   = shift_in(addr, io_s, lanes);
					next_bitcnt = bitcnt + 5'(lanes);
					if (next_bitcnt == 5'(`FID_ADDR_BITS))
					begin
						next_st   = fid_pkg::ST_OUT;
						next_plen = 5'd16;
						next_pat  = next_addr[0] ? {DEVICE_ID, MAKER_ID, 8'h00}
							: {MAKER_ID, DEVICE_ID, 8'h00};
					end
				end
				fid_pkg::ST_DUMMY:
				begin
					next_bitcnt = bitcnt + 5'd1;
					if (next_bitcnt == 5'(`FID_DUMMY_BITS))
					begin
						next_st   = fid_pkg::ST_OUT;
						next_plen = 5'd8;
						next_pat  = {DEVICE_ID, 16'h0000};
					end
				end
				fid_pkg::ST_END:
					next_st = fid_pkg::ST_DROP;
				default:
					next_st = st;
			endcase
		end
		else if (sck_fall && st == fid_pkg::ST_OUT)
		begin
			// Pattern repeats while select stays low
			unique case (lanes)
				3'd1:    next_io_out = {2'b00, cur[23], 1'b0};
				3'd2:    next_io_out = {2'b00, cur[23:22]};
				default: next_io_out = cur[23:20];
			endcase
			next_io_oe = lane_oe(lanes);
			next_sr    = cur << lanes;
			next_ocnt  = ((ocnt == 5'd0) ? plen : ocnt) - 5'(lanes);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st     <= fid_pkg::ST_IDLE;
			cmd    <= 8'h00;
			bitcnt <= 5'd0;
			lanes  <= 3'd1;
			addr   <= 24'h0;
			sr     <= 24'h0;
			pat    <= 24'h0;
			plen   <= 5'd8;
			ocnt   <= 5'd0;
			io_out <= 4'h0;
			io_oe  <= 4'h0;
		end
		else
		begin
			st     <= next_st;
			cmd    <= next_cmd;
			bitcnt <= next_bitcnt;
			lanes  <= next_lanes;
			addr   <= next_addr;
			sr     <= next_sr;
			pat    <= next_pat;
			plen   <= next_plen;
			ocnt   <= next_ocnt;
			io_out <= next_io_out;
			io_oe  <= next_io_oe;
		end
	end

	assign go_erase   = cs_rise && st == fid_pkg::ST_END
		&& (cmd == fid_pkg::OP_ERASE_A || cmd == fid_pkg::OP_ERASE_B);
	assign go_unlock  = cs_rise && st == fid_pkg::ST_END && cmd == fid_pkg::OP_WRITE_UNLOCK;
	assign go_sleep   = cs_rise && st == fid_pkg::ST_END && cmd == fid_pkg::OP_DEEP_SLEEP;
	assign go_wake    = cs_rise && st == fid_pkg::ST_DUMMY && bitcnt == 5'd0
		&& cmd == fid_pkg::OP_WAKE_AND_ID;
	assign go_wake_id = cs_rise && st != fid_pkg::ST_CMD && !go_wake
		&& cmd == fid_pkg::OP_WAKE_AND_ID && st != fid_pkg::ST_DROP;

	// ---------------------------------------------------------------
	// Erase, latch and power state
	// ---------------------------------------------------------------
	logic [3:0]  prot;
	logic        write_enable_latch,  next_wel;
	logic        next_busy;
	fid_pkg::fid_pm_t next_pm;
	logic        tstart;
	logic [31:0] tload;
	logic        tdone;
	logic        prot_ok;

	assign prot_ok = (prot[2:0] == 3'b000 && !prot[`FID_PROT_CMP])
		|| (prot[2:0] == 3'b111 && prot[`FID_PROT_CMP]);

	fid_timer u_timer
	(
		.pclk    (pclk),
		.presetn (presetn),
		.start   (tstart),
		.load    (tload),
		.done    (tdone)
	);

	always_comb
	begin
		next_wel  = write_enable_latch;
		next_busy = busy;
		next_pm   = pm;
		tstart    = 1'b0;
		tload     = ERASE_CYCLES;
		if (tdone)
		begin
			next_busy = 1'b0;
			if (pm == fid_pkg::PM_ENTER)
				next_pm = fid_pkg::PM_SLEEP;
			else if (pm == fid_pkg::PM_WAKE)
				next_pm = fid_pkg::PM_ACTIVE;
		end
		else if (go_unlock)
			next_wel = 1'b1;
		else if (go_erase && write_enable_latch && prot_ok)
		begin
			next_busy = 1'b1;
			next_wel  = 1'b0;
			tstart    = 1'b1;
		end
		else if (go_sleep)
		begin
			next_pm = fid_pkg::PM_ENTER;
			tstart  = 1'b1;
			tload   = 32'(`FID_SLEEP_CYC);
		end
		else if ((go_wake || go_wake_id) && pm == fid_pkg::PM_SLEEP)
		begin
			next_pm = fid_pkg::PM_WAKE;
			tstart  = 1'b1;
			tload   = go_wake ? 32'(`FID_WAKE_CYC) : 32'(`FID_WAKE_ID_CYC);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			write_enable_latch  <= 1'b0;
			busy <= 1'b0;
			pm   <= fid_pkg::PM_ACTIVE;
		end
		else
		begin
			write_enable_latch  <= next_wel;
			busy <= next_busy;
			pm   <= next_pm;
		end
	end

	// ---------------------------------------------------------------
	// APB slave
	// ---------------------------------------------------------------
	logic [3:0]  next_prot;
	logic        next_pready;
	logic [31:0] next_prdata;
	logic        next_pslverr;

	always_comb
	begin
		next_prot    = prot;
		next_pready  = psel && penable && !pready;
		next_prdata  = prdata;
		next_pslverr = pslverr;
		if (next_pready)
		begin
			next_prdata  = 32'h0;
			next_pslverr = 1'b0;
			unique case (paddr)
				`FID_OFS_PROT:   next_prdata[3:0] = prot;
				`FID_OFS_STATUS: next_prdata[3:0] = {pm, write_enable_latch, busy};
				default:         next_pslverr = 1'b1;
			endcase
		end
		if (psel && penable && pready && pwrite && pstrb[0] && paddr == `FID_OFS_PROT)
			next_prot = pwdata[3:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prot    <= `FID_PROT_RESET;
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end
		else
		begin
			prot    <= next_prot;
			pready  <= next_pready;
			prdata  <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	erase_opcode_a: assert property ($rose(busy) |-> $past(cmd == fid_pkg::OP_ERASE_A
		|| cmd == fid_pkg::OP_ERASE_B)) else $error("Erase started by wrong opcode");
	erase_latch_a: assert property ($rose(busy) |-> $past(write_enable_latch) && !write_enable_latch)
		else $error("Erase started without latch or latch kept");
	erase_select_a: assert property ($rose(busy) |-> $past(st == fid_pkg::ST_END))
		else $error("Erase started without clean select rise");
	erase_prot_a: assert property ($rose(busy) |-> $past(prot_ok))
		else $error("Erase started while protected");
	sleep_refuse_a: assert property (busy && pm == fid_pkg::PM_ACTIVE
		|=> pm == fid_pkg::PM_ACTIVE) else $error("Sleep entered while busy");
	sleep_entry_a: assert property ($rose(pm == fid_pkg::PM_ENTER) |-> $past(go_sleep))
		else $error("Sleep entry without command");
	sleep_hold_a: assert property (pm == fid_pkg::PM_SLEEP && !busy
		|=> !busy && pm != fid_pkg::PM_ACTIVE) else $error("Sleep left or busy");
	busy_quiet_a: assert property (busy |-> io_oe == 4'h0)
		else $error("Output driven while busy");
	select_end_a: assert property (cs_rise |=> io_oe == 4'h0)
		else $error("Output still driven after select rise");

endmodule // fid_core

`default_nettype wire

// [sim/fid_host.sv]
// Purpose: Host serial controller model for the flash command core
// Assumes: Mode 0 framing, sclk period of 20 pclk (160 ns)
// Notes:   Lines the device leaves alone carry a pattern that flips
`timescale 1ns/1ns
`default_nettype none

module fid_host
(
	input  wire logic       pclk,
	output logic            cs_n,
	output logic            sclk,
	output logic      [3:0] io_in,
	input  wire logic [3:0] io_out,
	input  wire logic [3:0] io_oe
);
	logic [3:0] hd;

	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		hd = 4'h0;
	end

	// Wire level from both drivers
	assign io_in = (io_oe & io_out) | (~io_oe & hd);

	// ---------------------------------------------------------------
	// One clock: data set while low, sampled just before the rise
	// ---------------------------------------------------------------
	task automatic bit_clk(input logic [3:0] v, output logic [3:0] s);
		hd <= v;
		repeat (9) @(posedge pclk);
		s = io_in;
		@(posedge pclk);
		sclk <= 1'b1;
		repeat (10) @(posedge pclk);
		sclk <= 1'b0;
	endtask

	// ---------------------------------------------------------------
	// Whole frame: opcode, address or dummy bits, readout
	// ---------------------------------------------------------------
	task automatic frame(input logic [7:0] op, input int na, input logic [23:0] ad,
		input int ln, input int nout, output logic [23:0] rd);
		logic [3:0] s;
		logic [3:0] m;
		m = 4'((1 << ln) - 1);
		rd = 24'h0;
		cs_n <= 1'b0;
		for (int i = 7; i >= 0; i--)
		begin
			bit_clk({3'h0, op[i]}, s);
		end
		for (int i = na / ln - 1; i >= 0; i--)
		begin
			bit_clk(4'(ad >> (i * ln)) & m, s);
		end
		for (int i = 0; i < nout / ln; i++)
		begin
			bit_clk(~hd, s);
			rd = (rd << ln) | 24'((ln == 1) ? {3'h0, s[1]} : s & m);
		end
		repeat (10) @(posedge pclk);
		cs_n <= 1'b1;
		hd <= ~hd;
	endtask
endmodule // fid_host

`default_nettype wire

// [sim/flash_erase_powerdown_id_cmds_test.sv]
// Purpose: Self-checking bench for the erase, sleep and identification core
// Assumes: Erase shortened to 3000 cycles
// Notes:   Status bits: busy, latch, power state in [3:2]
`timescale 1ns/1ns
`default_nettype none

module flash_erase_powerdown_id_cmds_test;
	localparam logic [7:0] MK = 8'h5a;
	localparam logic [7:0] MT = 8'h3c;
	localparam logic [7:0] CP = 8'h18;
	localparam logic [7:0] DV = 8'h17;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cs_n;
	logic        sclk;
	logic [3:0]  io_in;
	logic [3:0]  io_out;
	logic [3:0]  io_oe;
	logic        oe_seen;
	logic [31:0] q;
	logic        e;
	logic [23:0] rd;
	int          n_fail;
	int          n_checks;

	fid_core #(.ERASE_CYCLES(32'd3000), .MAKER_ID(MK), .MEM_TYPE(MT), .CAPACITY(CP),
		.DEVICE_ID(DV)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cs_n(cs_n), .sclk(sclk),
		.io_in(io_in), .io_out(io_out), .io_oe(io_oe));

	fid_host u_host (.pclk(pclk), .cs_n(cs_n), .sclk(sclk), .io_in(io_in),
		.io_out(io_out), .io_oe(io_oe));

	initial
	begin
		pclk = 1'b0;
	end

	always #4 pclk = ~pclk;

	always @(posedge pclk)
	begin
		if (io_oe !== 4'h0)
			oe_seen <= 1'b1;
	end

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic chk_reg(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_checks++;
		if (got !== ex)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic chk_ser(input string nm, input logic [23:0] ex, input logic [23:0] got);
		n_checks++;
		if (got !== ex)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic st(input logic [3:0] ex);
		apb(1'b0, 8'h04, 32'h0);
		chk_reg("status", {28'h0, ex}, q);
	endtask

	task automatic cmd(input logic [7:0] op, input int na, input logic [23:0] ad,
		input int ln, input int nout);
		u_host.frame(op, na, ad, ln, nout, rd);
		repeat (20) @(posedge pclk);
	endtask

	task automatic op1(input logic [7:0] op);
		cmd(op, 0, 24'h0, 1, 0);
	endtask

	task automatic end_of_test;
		$display("checks %0d errors %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		repeat (60000) @(posedge pclk);
		n_fail++;
		end_of_test;
	end

	// ---------------------------------------------------------------
	// Sequence
	// ---------------------------------------------------------------
	initial
	begin
		int n;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hf;
		oe_seen = 1'b0;
		n_fail = 0;
		n_checks = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		st(4'h0);
		apb(1'b0, 8'h08, 32'h0);
		chk_reg("unmapped", 32'h1, {31'h0, e});
		pstrb <= 4'h0;
		apb(1'b1, 8'h00, 32'hf);
		pstrb <= 4'hf;
		apb(1'b0, 8'h00, 32'h0);
		chk_reg("prot", 32'h0, q);
		cmd(8'h9f, 0, 24'h0, 1, 12);
		cmd(8'h9f, 0, 24'h0, 1, 24);
		chk_ser("full_id", {MK, MT, CP}, rd);
		for (int k = 0; k < 6; k++)
		begin
			cmd(8'h90 + 8'(2 * (k % 3)), 24, 24'(k / 3), 1 << (k % 3), 16);
			chk_ser("maker_dev", (k < 3) ? {8'h0, MK, DV} : {8'h0, DV, MK}, rd);
		end
		cmd(8'hab, 24, 24'h0, 1, 16);
		chk_ser("dev_repeat", {8'h0, DV, DV}, rd);
		op1(8'h60);
		st(4'h0);
		op1(8'h06);
		apb(1'b1, 8'h00, 32'h1);
		op1(8'h60);
		st(4'h2);
		apb(1'b1, 8'h00, 32'h7);
		op1(8'hc7);
		st(4'h2);
		apb(1'b1, 8'h00, 32'h0);
		cmd(8'h60, 0, 24'h0, 1, 1);
		st(4'h2);
		for (int k = 0; k < 2; k++)
		begin
			apb(1'b1, 8'h00, (k == 1) ? 32'hf : 32'h0);
			op1(8'h06);
			op1((k == 1) ? 8'hc7 : 8'h60);
			st(4'h1);
			oe_seen <= 1'b0;
			op1(8'hb9);
			st(4'h1);
			op1(8'hab);
			st(4'h1);
			cmd(8'h9f, 0, 24'h0, 1, 8);
			chk_reg("quiet", 32'h0, {31'h0, oe_seen});
			n = 0;
			do
			begin
				apb(1'b0, 8'h04, 32'h0);
				n++;
			end
			while (q[0] !== 1'b0 && n < 1000);
			st(4'h0);
		end
		cmd(8'hb9, 0, 24'h0, 1, 1);
		st(4'h0);
		op1(8'hb9);
		st(4'h4);
		repeat (400) @(posedge pclk);
		st(4'h8);
		oe_seen <= 1'b0;
		op1(8'h06);
		cmd(8'h90, 24, 24'h0, 1, 16);
		st(4'h8);
		chk_reg("asleep", 32'h0, {31'h0, oe_seen});
		op1(8'hab);
		st(4'hc);
		repeat (400) @(posedge pclk);
		st(4'h0);
		op1(8'hb9);
		repeat (400) @(posedge pclk);
		cmd(8'hab, 24, 24'h0, 1, 8);
		chk_ser("wake_id", {16'h0, DV}, rd);
		st(4'hc);
		repeat (1050) @(posedge pclk);
		st(4'h0);
		op1(8'hb9);
		repeat (400) @(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		st(4'h0);
		end_of_test;
	end
endmodule // flash_erase_powerdown_id_cmds_test

`default_nettype wire
